// ==== hdl/tsc_config_regs.sv ====
// register bank, conversion timing and flag pin of the temperature sensor
// Overview of operation
// - configuration is 16-bit read/write, low byte read-only on the reduced variant, moved most significant byte first
// - configuration resets to 00FFh standard, 60A0h reduced variant
// - writing 1 to bit 15 with bit 8 set in the same write starts one conversion; bit reads 0
// - bits 14:13 pick the continuous period; reduced variant fixed 11, 250 ms
// - bits 12:11 pick consecutive faults needed; reduced codes 10/11 mean 4/6
// - bit 10 sets flag pin sense: 0 active low, 1 active high
// - bit 9 selects comparator mode at 0, interrupt mode at 1
// - bit 8 selects continuous conversion at 0, shutdown at 1
// - single-byte configuration write updates only bits 15-8
// - single-byte configuration read returns only bits 15-8
// - low limit holds 12-bit value in 15:4, resets to 4B00h
// - high limit holds 12-bit value in 15:4, resets to 5000h
// - standard variant has a read-only identification register; reduced lacks it
// - comparator: assert at or above high, release below low, after count
// - interrupt: cleared by read or alert response, then other limit; shutdown clears and goes back to high
module tsc_config_regs #(
    parameter bit          REDUCED      = 1'b0,
    parameter logic [15:0] IDENT_VALUE  = 16'hA500, // arbitrary value
    parameter int          RATE0_CYC    = tsc_pkg::RATE0_CYC,
    parameter int          RATE1_CYC    = tsc_pkg::RATE1_CYC,
    parameter int          RATE2_CYC    = tsc_pkg::RATE2_CYC,
    parameter int          RATE3_CYC    = tsc_pkg::RATE3_CYC,
    parameter int          RATE_RED_CYC = tsc_pkg::RATE_RED_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wrEn,
    input  wire logic        wrSingle,
    input  wire logic [7:0]  wrAddr,
    input  wire logic [15:0] wrData,
    input  wire logic        rdEn,
    input  wire logic        rdSingle,
    input  wire logic [7:0]  rdAddr,
    input  wire logic        tempValid,
    input  wire logic [11:0] tempValue,
    input  wire logic        alertResp,
    output logic [15:0]      rdData,
    output logic             rdValid,
    output logic             convStart,
    output logic             powerDown,
    output logic             alertPin
);
    localparam logic [15:0] CFG_RST = REDUCED ? tsc_pkg::CFG_RST_RED : tsc_pkg::CFG_RST_STD;
    localparam int          TW      = tsc_pkg::TIMER_W;

    logic [15:0]   cfg_r;
    logic [15:0]   cfg_nxt;
    logic [15:0]   lowLim_r;
    logic [15:0]   lowLim_nxt;
    logic [15:0]   highLim_r;
    logic [15:0]   highLim_nxt;
    logic [15:0]   rdData_r;
    logic [15:0]   rdData_nxt;
    logic          rdValid_r;
    logic          rdValid_nxt;
    logic [TW-1:0] timer_r;
    logic [TW-1:0] timer_nxt;
    logic          convStart_r;
    logic          convStart_nxt;
    logic          alert_r;
    logic          alert_nxt;
    logic          useLow_r;
    logic          useLow_nxt;
    logic          alertPin_r;
    logic          alertPin_nxt;
    logic          filtClr;
    logic          filtCond;
    logic          filtHit;
    logic          cfgWr;
    logic          trigWr;

    // period reload for the selected rate code
    function automatic logic [TW-1:0] periodOf(input logic [1:0] code);
        logic [TW-1:0] p;
        p = TW'(RATE3_CYC);
        if (REDUCED) begin
            p = TW'(RATE_RED_CYC);
        end else begin
            unique case (code)
                2'h0: p = TW'(RATE0_CYC);
                2'h1: p = TW'(RATE1_CYC);
                2'h2: p = TW'(RATE2_CYC);
                2'h3: p = TW'(RATE3_CYC);
            endcase
        end
        return p;
    endfunction

    function automatic logic [2:0] faultsOf(input logic [1:0] code);
        logic [2:0] n;
        n = 3'd1;
        unique case (code)
            2'h0: n = 3'd1;
            2'h1: n = 3'd2;
            2'h2: n = REDUCED ? tsc_pkg::FAULTS_RED_2 : tsc_pkg::FAULTS_STD_2;
            2'h3: n = REDUCED ? tsc_pkg::FAULTS_RED_3 : tsc_pkg::FAULTS_STD_3;
        endcase
        return n;
    endfunction

    // register writes
    always_comb begin
        cfg_nxt     = cfg_r;
        lowLim_nxt  = lowLim_r;
        highLim_nxt = highLim_r;
        cfgWr       = wrEn && (wrAddr == tsc_pkg::ADDR_CONFIG);
        trigWr      = cfgWr && wrData[tsc_pkg::CFG_TRIG_BIT];
        if (cfgWr) begin
            cfg_nxt[15:8] = wrData[15:8];
            if (!wrSingle && !REDUCED) begin
                cfg_nxt[7:0] = wrData[7:0];
            end
            cfg_nxt[tsc_pkg::CFG_TRIG_BIT] = 1'b0;
            if (REDUCED) begin
                cfg_nxt[tsc_pkg::CFG_RATE_HI:tsc_pkg::CFG_RATE_LO] =
                    tsc_pkg::RATE_FIXED_RED;
            end
        end
        if (wrEn && wrAddr == tsc_pkg::ADDR_LOW_LIM) begin
            lowLim_nxt = {wrData[tsc_pkg::LIM_MSB:tsc_pkg::LIM_LSB], 4'h0};
        end
        if (wrEn && wrAddr == tsc_pkg::ADDR_HIGH_LIM) begin
            highLim_nxt = {wrData[tsc_pkg::LIM_MSB:tsc_pkg::LIM_LSB], 4'h0};
        end
        // identification address has no write path
    end

    // register reads, answered one cycle after rdEn
    always_comb begin
        rdValid_nxt = rdEn;
        rdData_nxt  = rdData_r;
        if (rdEn) begin
            unique case (rdAddr)
                tsc_pkg::ADDR_CONFIG: begin
                    rdData_nxt = cfg_r;
                    if (rdSingle) begin
                        rdData_nxt = {cfg_r[15:8], 8'h00};
                    end
                end
                tsc_pkg::ADDR_LOW_LIM:  rdData_nxt = lowLim_r;
                tsc_pkg::ADDR_HIGH_LIM: rdData_nxt = highLim_r;
                tsc_pkg::ADDR_IDENT:    rdData_nxt = REDUCED ? 16'h0000 : IDENT_VALUE;
                default:                rdData_nxt = 16'h0000;
            endcase
        end
    end

    // conversion timing
    always_comb begin
        timer_nxt     = timer_r;
        convStart_nxt = 1'b0;
        if (cfg_r[tsc_pkg::CFG_PDOWN_BIT]) begin
            timer_nxt = '0;
        end else if (timer_r == '0) begin
            convStart_nxt = 1'b1;
            timer_nxt     = periodOf(cfg_r[tsc_pkg::CFG_RATE_HI:tsc_pkg::CFG_RATE_LO]) -
                            TW'(1);
        end else begin
            timer_nxt = timer_r - TW'(1);
        end
        // one-shot needs the same write to ask for shutdown, else the run covers it
        if (trigWr && wrData[tsc_pkg::CFG_PDOWN_BIT]) begin
            convStart_nxt = 1'b1;
        end
    end

    // flag pin logic
    always_comb begin
        logic funcChg;
        logic sdSet;
        logic clrEvt;
        funcChg  = cfgWr && (cfg_nxt[tsc_pkg::CFG_FUNC_BIT] != cfg_r[tsc_pkg::CFG_FUNC_BIT]);
        sdSet    = cfgWr && cfg_nxt[tsc_pkg::CFG_PDOWN_BIT];
        clrEvt   = rdEn || alertResp || sdSet;
        alert_nxt  = alert_r;
        useLow_nxt = useLow_r;
        filtClr    = funcChg;
        // comparator looks at the low limit while asserted
        if (!cfg_r[tsc_pkg::CFG_FUNC_BIT]) begin
            filtCond = alert_r ?
                ($signed(tempValue) < $signed(lowLim_r[15:4])) :
                ($signed(tempValue) >= $signed(highLim_r[15:4]));
        end else begin
            filtCond = useLow_r ?
                ($signed(tempValue) < $signed(lowLim_r[15:4])) :
                ($signed(tempValue) >= $signed(highLim_r[15:4]));
        end
        if (funcChg) begin
            alert_nxt  = 1'b0;
            useLow_nxt = 1'b0;
        end else if (!cfg_r[tsc_pkg::CFG_FUNC_BIT]) begin
            if (filtHit) begin
                alert_nxt = !alert_r;
            end
        end else begin
            if (sdSet) begin
                // shutdown also clears the history
                alert_nxt  = 1'b0;
                useLow_nxt = 1'b0;
                filtClr    = 1'b1;
            end else if (alert_r && clrEvt) begin
                alert_nxt  = 1'b0;
                useLow_nxt = !useLow_r;
                filtClr    = 1'b1;
            end else if (!alert_r && filtHit) begin
                alert_nxt = 1'b1;
            end
        end
        alertPin_nxt = cfg_nxt[tsc_pkg::CFG_SENSE_BIT] ? alert_nxt : !alert_nxt;
    end

    tsc_fault_filter u_filter (
        .clk    (clk),
        .rst_n  (rst_n),
        .clr    (filtClr),
        .sample (tempValid && !alert_r ||
                 tempValid && !cfg_r[tsc_pkg::CFG_FUNC_BIT]),
        .cond   (filtCond),
        .need   (faultsOf(cfg_r[tsc_pkg::CFG_FAULT_HI:tsc_pkg::CFG_FAULT_LO])),
        .hit    (filtHit)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_r       <= CFG_RST;
            lowLim_r    <= tsc_pkg::LOW_LIM_RST;
            highLim_r   <= tsc_pkg::HIGH_LIM_RST;
            rdData_r    <= 16'h0000;
            rdValid_r   <= 1'b0;
            timer_r     <= '0;
            convStart_r <= 1'b0;
            alert_r     <= 1'b0;
            useLow_r    <= 1'b0;
            alertPin_r  <= 1'b1;
        end else begin
            cfg_r       <= cfg_nxt;
            lowLim_r    <= lowLim_nxt;
            highLim_r   <= highLim_nxt;
            rdData_r    <= rdData_nxt;
            rdValid_r   <= rdValid_nxt;
            timer_r     <= timer_nxt;
            convStart_r <= convStart_nxt;
            alert_r     <= alert_nxt;
            useLow_r    <= useLow_nxt;
            alertPin_r  <= alertPin_nxt;
        end
    end

    assign rdData    = rdData_r;
    assign rdValid   = rdValid_r;
    assign convStart = convStart_r;
    assign powerDown = cfg_r[tsc_pkg::CFG_PDOWN_BIT];
    assign alertPin  = alertPin_r;
endmodule

// ==== hdl/tsc_pkg.sv ====
// constants shared by the temperature sensor register bank
package tsc_pkg;
    localparam int CLK_MHZ = 25;

    // register pointer values
    localparam logic [7:0] ADDR_CONFIG   = 8'h01;
    localparam logic [7:0] ADDR_LOW_LIM  = 8'h02;
    localparam logic [7:0] ADDR_HIGH_LIM = 8'h03;
    localparam logic [7:0] ADDR_IDENT    = 8'h0F;

    // configuration field positions
    localparam int CFG_TRIG_BIT   = 15;
    localparam int CFG_RATE_HI    = 14;
    localparam int CFG_RATE_LO    = 13;
    localparam int CFG_FAULT_HI   = 12;
    localparam int CFG_FAULT_LO   = 11;
    localparam int CFG_SENSE_BIT  = 10;
    localparam int CFG_FUNC_BIT   = 9;
    localparam int CFG_PDOWN_BIT  = 8;

    // values after reset
    localparam logic [15:0] CFG_RST_STD   = 16'h00FF;
    localparam logic [15:0] CFG_RST_RED   = 16'h60A0;
    localparam logic [15:0] LOW_LIM_RST   = 16'h4B00;
    localparam logic [15:0] HIGH_LIM_RST  = 16'h5000;
    localparam logic [1:0]  RATE_FIXED_RED = 2'h3;

    // limit field: 12-bit two's complement in bits 15:4
    localparam int LIM_MSB = 15;
    localparam int LIM_LSB = 4;

    // continuous conversion periods in microseconds
    localparam int RATE0_US    = 27500;
    localparam int RATE1_US    = 55000;
    localparam int RATE2_US    = 110000;
    localparam int RATE3_US    = 220000;
    localparam int RATE_RED_US = 250000;
    localparam int RATE0_CYC    = RATE0_US * CLK_MHZ;
    localparam int RATE1_CYC    = RATE1_US * CLK_MHZ;
    localparam int RATE2_CYC    = RATE2_US * CLK_MHZ;
    localparam int RATE3_CYC    = RATE3_US * CLK_MHZ;
    localparam int RATE_RED_CYC = RATE_RED_US * CLK_MHZ;
    localparam int TIMER_W      = 23;

    // consecutive faults needed per code
    localparam logic [2:0] FAULTS_STD_2 = 3'd3;
    localparam logic [2:0] FAULTS_STD_3 = 3'd4;
    localparam logic [2:0] FAULTS_RED_2 = 3'd4;
    localparam logic [2:0] FAULTS_RED_3 = 3'd6;
endpackage

// ==== hdl/tsc_fault_filter.sv ====
// consecutive out-of-limit counter for the flag pin
module tsc_fault_filter (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clr,
    input  wire logic       sample,
    input  wire logic       cond,
    input  wire logic [2:0] need,
    output logic            hit
);
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;

    // hit is combinational so the flag moves on the same sample edge
    always_comb begin
        cnt_nxt = cnt_r;
        hit     = 1'b0;
        if (clr) begin
            cnt_nxt = 3'h0;
        end else if (sample) begin
            if (!cond) begin
                cnt_nxt = 3'h0;
            end else if (cnt_r + 3'h1 >= need) begin
                cnt_nxt = 3'h0;
                hit     = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 3'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= 3'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ==== sim/tsc_config_regs_assertions.sv ====
// concurrent checks on the sensor register bank ports
module tsc_config_regs_chk #(
    parameter bit          REDUCED     = 1'b0,
    parameter logic [15:0] IDENT_VALUE = 16'hA500 // arbitrary value
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        wrEn,
    input wire logic        wrSingle,
    input wire logic [7:0]  wrAddr,
    input wire logic [15:0] wrData,
    input wire logic        rdEn,
    input wire logic        rdSingle,
    input wire logic [7:0]  rdAddr,
    input wire logic        tempValid,
    input wire logic [11:0] tempValue,
    input wire logic        alertResp,
    input wire logic [15:0] rdData,
    input wire logic        rdValid,
    input wire logic        convStart,
    input wire logic        powerDown,
    input wire logic        alertPin
);
    localparam logic [7:0] CFG = tsc_pkg::ADDR_CONFIG;
    logic [7:0] lastAddr_r;
    logic [7:0] lastAddr_nxt;
    logic       lastSingle_r;
    logic       lastSingle_nxt;
    logic       cfgWr;
    assign cfgWr = wrEn && wrAddr == CFG;
    // remembers what the answered read asked for
    always_comb begin
        lastAddr_nxt = rdEn ? rdAddr : lastAddr_r;
        lastSingle_nxt = rdEn ? rdSingle : lastSingle_r;
    end
    always_ff @(posedge clk) begin
        lastAddr_r <= lastAddr_nxt;
        lastSingle_r <= lastSingle_nxt;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_RD_ANSWER: assert property (rdEn |=> rdValid)
        else $error("read request without answer");
    AST_RD_NOEXTRA: assert property (!rdEn |=> !rdValid)
        else $error("read answer without request");
    AST_TRIG_READ0: assert property (rdValid && lastAddr_r == CFG |-> !rdData[15])
        else $error("trigger bit read back as one");
    AST_SINGLE_READ: assert property (rdValid && lastAddr_r == CFG && lastSingle_r
        |-> rdData[7:0] == 8'h00)
        else $error("single read carried low byte");
    AST_LIM_NIBBLE: assert property (rdValid
        && (lastAddr_r == tsc_pkg::ADDR_LOW_LIM || lastAddr_r == tsc_pkg::ADDR_HIGH_LIM)
        |-> rdData[3:0] == 4'h0)
        else $error("limit low nibble not zero");
    AST_IDENT_READ: assert property (rdValid
        && lastAddr_r == tsc_pkg::ADDR_IDENT |-> rdData == (REDUCED ? 16'h0000 : IDENT_VALUE))
        else $error("identification value wrong");
    AST_PDOWN_WRITE: assert property (cfgWr |=> powerDown == $past(wrData[8]))
        else $error("power down bit not taken");
    AST_ONE_SHOT: assert property (cfgWr && wrData[15] && wrData[8] |=> convStart)
        else $error("one-shot write gave no start");
    AST_SHUT_QUIET: assert property (convStart && powerDown && $past(powerDown)
        |-> $past(cfgWr && wrData[15]))
        else $error("start pulse during shutdown");
    AST_ALERT_HOLD: assert property (!tempValid && !rdEn && !wrEn && !alertResp
        |=> $stable(alertPin))
        else $error("flag pin moved without cause");
endmodule
bind tsc_config_regs tsc_config_regs_chk #(.REDUCED(REDUCED), .IDENT_VALUE(IDENT_VALUE)) chk (
    .clk(clk), .rst_n(rst_n), .wrEn(wrEn), .wrSingle(wrSingle), .wrAddr(wrAddr),
    .wrData(wrData), .rdEn(rdEn), .rdSingle(rdSingle), .rdAddr(rdAddr),
    .tempValid(tempValid), .tempValue(tempValue), .alertResp(alertResp),
    .rdData(rdData), .rdValid(rdValid), .convStart(convStart),
    .powerDown(powerDown), .alertPin(alertPin)
);

// ==== sim/tsc_host_model.sv ====
// serial host model driving the register port of the sensor
module tsc_host_model (
    input  wire logic        clk,
    output logic             wrEn,
    output logic             wrSingle,
    output logic [7:0]       wrAddr,
    output logic [15:0]      wrData,
    output logic             rdEn,
    output logic             rdSingle,
    output logic [7:0]       rdAddr,
    output logic             alertResp,
    input  wire logic [15:0] rdData,
    input  wire logic        rdValid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {wrEn, wrSingle, rdEn, rdSingle, alertResp} = 5'h00;
        {wrAddr, rdAddr, wrData} = 32'h0000_0000;
    end
    // released lines show the inverse, never a stale copy
    task wr(input logic [7:0] a, input logic [15:0] d, input logic s);
        @(posedge clk);
        wrEn <= 1'b1;
        wrAddr <= a;
        wrData <= d; // first byte on the wire sits in 15:8
        wrSingle <= s; // only single access to config on the reduced part
        @(posedge clk);
        wrEn <= 1'b0;
        wrAddr <= ~a;
        wrData <= ~d;
        wrSingle <= ~s;
    endtask
    task rd(input logic [7:0] a, input logic s, output logic [15:0] d, output logic ok);
        @(posedge clk);
        rdEn <= 1'b1;
        rdAddr <= a;
        rdSingle <= s;
        @(posedge clk);
        rdEn <= 1'b0;
        rdAddr <= ~a;
        rdSingle <= ~s;
        #1;
        ok = rdValid;
        d = rdData;
    endtask
    task alert();
        @(posedge clk);
        alertResp <= 1'b1;
        @(posedge clk);
        alertResp <= 1'b0;
    endtask
endmodule

// ==== sim/tsc_config_regs_test.sv ====
// self-checking bench for the sensor register bank
module tsc_config_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] IDV = 16'hA500; // arbitrary value
    localparam int PER[4] = '{20, 30, 40, 50};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        tempValid = 1'b0;
    logic [11:0] tempValue = 12'h000;
    logic        wrEn, wrSingle, rdEn, rdSingle, alertResp;
    logic        rdValid, convStart, powerDown, alertPin;
    logic [7:0]  wrAddr, rdAddr;
    logic [15:0] wrData, rdData;
    logic [31:0] seed = 32'd91;
    int          fail_count = 0;
    int          n_compared = 0;
    always #20 clk = ~clk;
    tsc_host_model host (.clk(clk), .wrEn(wrEn), .wrSingle(wrSingle), .wrAddr(wrAddr),
        .wrData(wrData), .rdEn(rdEn), .rdSingle(rdSingle), .rdAddr(rdAddr),
        .alertResp(alertResp), .rdData(rdData), .rdValid(rdValid));
    tsc_config_regs #(.IDENT_VALUE(IDV), .RATE0_CYC(PER[0]), .RATE1_CYC(PER[1]),
        .RATE2_CYC(PER[2]), .RATE3_CYC(PER[3])) dut (.clk(clk), .rst_n(rst_n),
        .wrEn(wrEn), .wrSingle(wrSingle), .wrAddr(wrAddr), .wrData(wrData), .rdEn(rdEn),
        .rdSingle(rdSingle), .rdAddr(rdAddr), .tempValid(tempValid), .tempValue(tempValue),
        .alertResp(alertResp), .rdData(rdData), .rdValid(rdValid), .convStart(convStart),
        .powerDown(powerDown), .alertPin(alertPin));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] cfgExp(input logic [15:0] v);
        return {1'b0, v[14:0]};
    endfunction
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic rdChk(input logic [7:0] a, input logic s, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        host.rd(a, s, d, ok);
        check("rdValid", 16'h0001, {15'h0, ok});
        check("rdData", exp, d);
    endtask
    // drive one result and look at the flag pin one cycle later
    task automatic tempChk(input logic [11:0] t, input logic e);
        @(posedge clk);
        tempValid <= 1'b1;
        tempValue <= t;
        @(posedge clk);
        tempValid <= 1'b0;
        tempValue <= ~t;
        #1;
        check("alertPin", {15'h0, e}, {15'h0, alertPin});
    endtask
    task automatic countConv(input int span, output int n);
        n = 0;
        repeat (span) begin
            @(posedge clk);
            n += int'(convStart === 1'b1);
        end
    endtask
    task end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        fail_count++;
        end_of_test();
    end
    initial begin
        static logic [7:0]  ra[5] = '{8'h01, 8'h02, 8'h03, 8'h0F, 8'h55};
        static logic [15:0] re[5] = '{16'h00FF, 16'h4B00, 16'h5000, IDV, 16'h0000};
        logic [15:0] v, c;
        int          n;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ra[i]) rdChk(ra[i], 1'b0, re[i]);
        $display("test reset values ended");
        for (int i = 0; i < 6; i++) begin
            v = xs();
            host.wr(i[0] ? 8'h02 : 8'h03, v, 1'b0);
            rdChk(i[0] ? 8'h02 : 8'h03, 1'b0, v & 16'hFFF0);
            host.wr(i[0] ? 8'h0F : 8'h55, v, 1'b0);
            rdChk(8'h0F, 1'b0, IDV);
            c = xs();
            host.wr(8'h01, c, 1'b0);
            rdChk(8'h01, 1'b0, cfgExp(c));
            check("powerDown", {15'h0, c[8]}, {15'h0, powerDown});
            v = xs();
            host.wr(8'h01, {v[15:8], ~c[7:0]}, 1'b1);
            rdChk(8'h01, 1'b0, cfgExp({v[15:8], c[7:0]}));
            rdChk(8'h01, 1'b1, {1'b0, v[14:8], 8'h00});
        end
        $display("test register access ended");
        for (int r = 0; r < 4; r++) begin
            host.wr(8'h01, 16'(r) << 13, 1'b0);
            repeat (3) begin
                n = 0;
                do begin @(posedge clk); n++; end while (convStart !== 1'b1 && n < 200);
            end
            check("convGap", 16'(PER[r]), 16'(n));
        end
        host.wr(8'h01, 16'h8100, 1'b0);
        countConv(120, n);
        check("convCount", 16'h0001, 16'(n));
        $display("test conversion timing ended");
        host.wr(8'h01, 16'h0000, 1'b0);
        host.wr(8'h02, 16'h1000, 1'b0);
        host.wr(8'h03, 16'h1900, 1'b0);
        for (int f = 0; f < 4; f++) begin
            host.wr(8'h01, 16'(f) << 11, 1'b0);
            for (int i = 0; i <= f; i++) tempChk(12'h190 + xs() % 96, i != f);
            rdChk(8'h02, 1'b0, 16'h1000);
            check("alertPin", 16'h0000, {15'h0, alertPin});
            for (int i = 0; i <= f; i++) tempChk(12'h0FF - xs() % 96, i == f);
        end
        host.wr(8'h01, 16'h0400, 1'b0);
        #1;
        check("alertPin", 16'h0000, {15'h0, alertPin});
        host.wr(8'h01, 16'h0200, 1'b0);
        tempChk(12'h190, 1'b0);
        tempChk(12'h1A0, 1'b0);
        rdChk(8'h03, 1'b0, 16'h1900);
        check("alertPin", 16'h0001, {15'h0, alertPin});
        tempChk(12'h190, 1'b1);
        tempChk(12'h0F0, 1'b0);
        host.alert();
        #1;
        check("alertPin", 16'h0001, {15'h0, alertPin});
        tempChk(12'h190, 1'b0);
        host.wr(8'h01, 16'h0300, 1'b0);
        #1;
        check("alertPin", 16'h0001, {15'h0, alertPin});
        $display("test flag pin ended");
        end_of_test();
    end
endmodule
